// [logic/rrpci_pkg.sv]
package rrpci_pkg;

    // ****************************************************************
    // bus map, byte addresses of 32-bit words
    // ****************************************************************
    localparam int          RRPCI_AW        = 8;
    localparam logic [7:0]  RRPCI_RTB_LO    = 8'h20;
    localparam logic [7:0]  RRPCI_RTB_HI    = 8'h24;
    localparam logic [7:0]  RRPCI_CCMD_LO   = 8'h28;
    localparam logic [7:0]  RRPCI_CCMD_HI   = 8'h2C;
    localparam logic [7:0]  RRPCI_CTRL      = 8'h30;
    localparam logic [7:0]  RRPCI_STAT      = 8'h34;
    localparam logic [7:0]  RRPCI_CFG       = 8'h38;
    localparam logic [7:0]  RRPCI_ACT_LO    = 8'h3C;
    localparam logic [7:0]  RRPCI_ACT_HI    = 8'h40;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int          RRPCI_HOST_AW   = 39;
    localparam int          RRPCI_RTB_LSB   = 12;
    localparam int          RRPCI_HI_W      = RRPCI_HOST_AW - 32;
    localparam int          RRPCI_REQ_POS   = 31;
    localparam int          RRPCI_RGRAN_LSB = 29;
    localparam int          RRPCI_AGRAN_LSB = 27;
    localparam int          RRPCI_FM_LSB    = 0;
    localparam int          RRPCI_DID_LSB   = 0;
    localparam int          RRPCI_SID_LSB   = 16;
    localparam int          RRPCI_SETP_POS  = 30;
    localparam int          RRPCI_PTRS_POS  = 30;
    localparam int          RRPCI_FLSH_POS  = 0;

    // ****************************************************************
    // granularity encoding and reset values
    // ****************************************************************
    localparam logic [1:0]  RRPCI_GRAN_RSVD = 2'h0;
    localparam logic [1:0]  RRPCI_GRAN_GLB  = 2'h1;
    localparam logic [1:0]  RRPCI_GRAN_DOM  = 2'h2;
    localparam logic [1:0]  RRPCI_GRAN_DEV  = 2'h3;
    localparam logic [31:0] RRPCI_RST_WORD  = 32'h0000_0000;
    localparam logic        RRPCI_RST_FLSH  = 1'b0;

    typedef enum logic [1:0] {
        RRPCI_ENG_IDLE,
        RRPCI_ENG_FLUSH,
        RRPCI_ENG_INVAL,
        RRPCI_ENG_DONE
    } rrpci_eng_t;

endpackage : rrpci_pkg

// [logic/rrpci_inval_if.sv]
`timescale 1ns/1ns
interface rrpci_inval_if;
    logic        start;
    logic [1:0]  req_gran;
    logic [15:0] domain_identifier;
    logic [15:0] sid;
    logic [1:0]  fm;
    logic        flush_need;
    logic        done;
    logic [1:0]  act_gran;

    modport ctl (output start, req_gran, domain_identifier, sid, fm, flush_need, input done, act_gran);
    modport eng (input start, req_gran, domain_identifier, sid, fm, flush_need, output done, act_gran);
endinterface : rrpci_inval_if

// [logic/rrpci_inval_eng.sv]
`timescale 1ns/1ns
module rrpci_inval_eng
    import rrpci_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    rrpci_inval_if.eng       ifc,
    output logic             flush_req,
    input  wire logic        flush_ack,
    output logic             cc_inval_req,
    output logic [1:0]       cc_inval_gran,
    output logic [15:0]      cc_inval_did,
    output logic [15:0]      cc_inval_sid,
    output logic [1:0]       cc_inval_fm,
    input  wire logic        cc_inval_ack
);

    rrpci_eng_t  st_q, st_d;
    logic [1:0]  gran_q, gran_d;
    logic [15:0] did_q, did_d;
    logic [15:0] sid_q, sid_d;
    logic [1:0]  fm_q, fm_d;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        st_d   = st_q;
        gran_d = gran_q;
        did_d  = did_q;
        sid_d  = sid_q;
        fm_d   = fm_q;
        case (st_q)
            RRPCI_ENG_IDLE: begin
                if (ifc.start) begin
                    // reserved request is served as the coarsest, global
                    gran_d = (ifc.req_gran == RRPCI_GRAN_RSVD) ? RRPCI_GRAN_GLB : ifc.req_gran;
                    did_d  = ifc.domain_identifier;
                    sid_d  = ifc.sid;
                    fm_d   = ifc.fm;
                    st_d   = ifc.flush_need ? RRPCI_ENG_FLUSH : RRPCI_ENG_INVAL;
                end
            end
            RRPCI_ENG_FLUSH: begin
                if (flush_ack) begin
                    st_d = RRPCI_ENG_INVAL;
                end
            end
            RRPCI_ENG_INVAL: begin
                if (cc_inval_ack) begin
                    st_d = RRPCI_ENG_DONE;
                end
            end
            RRPCI_ENG_DONE: begin
                st_d = RRPCI_ENG_IDLE;
            end
            default: begin
                st_d = RRPCI_ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q   <= RRPCI_ENG_IDLE;
            gran_q <= RRPCI_GRAN_RSVD;
            did_q  <= 16'h0000;
            sid_q  <= 16'h0000;
            fm_q   <= 2'h0;
        end else begin
            st_q   <= st_d;
            gran_q <= gran_d;
            did_q  <= did_d;
            sid_q  <= sid_d;
            fm_q   <= fm_d;
        end
    end

    assign flush_req     = (st_q == RRPCI_ENG_FLUSH);
    assign cc_inval_req  = (st_q == RRPCI_ENG_INVAL);
    assign cc_inval_gran = gran_q;
    assign cc_inval_did  = did_q;
    assign cc_inval_sid  = sid_q;
    assign cc_inval_fm   = fm_q;
    assign ifc.done      = (st_q == RRPCI_ENG_DONE);
    assign ifc.act_gran  = gran_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence flush_seen_s;
        flush_req ##[0:1000] (flush_ack && flush_req) ##1 cc_inval_req;
    endsequence

    flush_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_q == RRPCI_ENG_IDLE && ifc.start && ifc.flush_need) |=> flush_req && !cc_inval_req)
        else $error("flush not issued before invalidation");

    flush_order_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_q == RRPCI_ENG_IDLE && ifc.start && ifc.flush_need) |=> flush_seen_s or (flush_req [*8]))
        else $error("invalidation did not follow flush");

    done_after_ack_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cc_inval_req && cc_inval_ack) |=> ifc.done ##1 !ifc.done)
        else $error("completion not one pulse after ack");

    gran_coarse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ifc.done |-> ifc.act_gran != RRPCI_GRAN_RSVD)
        else $error("reserved granularity reported");

endmodule : rrpci_inval_eng

// [logic/rrpci_regs.sv]
`timescale 1ns/1ns
module rrpci_regs
    import rrpci_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic [63:0]      active_root_ptr,
    output logic             flush_req,
    input  wire logic        flush_ack,
    output logic             cc_inval_req,
    output logic [1:0]       cc_inval_gran,
    output logic [15:0]      cc_inval_did,
    output logic [15:0]      cc_inval_sid,
    output logic [1:0]       cc_inval_fm,
    input  wire logic        cc_inval_ack
);

    rrpci_inval_if ifc ();

    // ****************************************************************
    // bus slave state
    // ****************************************************************
    logic                  dph_q, dph_d;
    logic                  dwr_q, dwr_d;
    logic [RRPCI_AW-1:0]   dadr_q, dadr_d;
    logic [31:0]           rdat_q, rdat_d;

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [31:RRPCI_RTB_LSB] rtb_lo_q, rtb_lo_d;
    logic [RRPCI_HI_W-1:0]   rtb_hi_q, rtb_hi_d;
    logic [31:RRPCI_RTB_LSB] act_lo_q, act_lo_d;
    logic [RRPCI_HI_W-1:0]   act_hi_q, act_hi_d;
    logic                    load_q, load_d;
    logic                    ptr_stat_q, ptr_stat_d;
    logic                    req_bit_q, req_bit_d;
    logic [1:0]              rgran_q, rgran_d;
    logic [1:0]              agran_q, agran_d;
    logic [15:0]             did_q, did_d;
    logic [15:0]             sid_q, sid_d;
    logic [1:0]              fm_q, fm_d;
    logic                    flush_need_q, flush_need_d;
    logic                    start_q, start_d;
    logic                    wr_now;

    function automatic logic hit(input logic [RRPCI_AW-1:0] a, input logic [RRPCI_AW-1:0] reg_a);
        hit = (a == reg_a);
    endfunction : hit

    // unimplemented high address bits and write-only fields read as zero
    function automatic logic [31:0] rd_word(input logic [RRPCI_AW-1:0] a);
        logic [31:0] w;
        w = RRPCI_RST_WORD;
        if (hit(a, RRPCI_RTB_LO)) begin
            w[31:RRPCI_RTB_LSB] = rtb_lo_q;
        end else if (hit(a, RRPCI_RTB_HI)) begin
            w[RRPCI_HI_W-1:0] = rtb_hi_q;
        end else if (hit(a, RRPCI_CCMD_LO)) begin
            w[RRPCI_DID_LSB +: 16] = did_q;
        end else if (hit(a, RRPCI_CCMD_HI)) begin
            w[RRPCI_REQ_POS] = req_bit_q;
            w[RRPCI_RGRAN_LSB +: 2] = rgran_q;
            w[RRPCI_AGRAN_LSB +: 2] = agran_q;
        end else if (hit(a, RRPCI_STAT)) begin
            w[RRPCI_PTRS_POS] = ptr_stat_q;
        end else if (hit(a, RRPCI_CFG)) begin
            w[RRPCI_FLSH_POS] = flush_need_q;
        end else if (hit(a, RRPCI_ACT_LO)) begin
            w[31:RRPCI_RTB_LSB] = act_lo_q;
        end else if (hit(a, RRPCI_ACT_HI)) begin
            w[RRPCI_HI_W-1:0] = act_hi_q;
        end
        rd_word = w;
    endfunction : rd_word

    // ****************************************************************
    // address and data phase
    // ****************************************************************
    always_comb begin
        dph_d  = hsel && htrans[1] && hready;
        dwr_d  = hwrite;
        dadr_d = haddr[RRPCI_AW-1:0];
        rdat_d = rdat_q;
        if (hsel && htrans[1] && hready && !hwrite) begin
            rdat_d = rd_word(haddr[RRPCI_AW-1:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_q  <= 1'b0;
            dwr_q  <= 1'b0;
            dadr_q <= '0;
            rdat_q <= RRPCI_RST_WORD;
        end else begin
            dph_q  <= dph_d;
            dwr_q  <= dwr_d;
            dadr_q <= dadr_d;
            rdat_q <= rdat_d;
        end
    end

    assign wr_now    = dph_q && dwr_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdat_q;

    // ****************************************************************
    // root table pointer
    // ****************************************************************
    always_comb begin
        rtb_lo_d = rtb_lo_q;
        rtb_hi_d = rtb_hi_q;
        act_lo_d = act_lo_q;
        act_hi_d = act_hi_q;
        load_d       = 1'b0;
        ptr_stat_d   = ptr_stat_q;
        flush_need_d = flush_need_q;
        if (wr_now && hit(dadr_q, RRPCI_RTB_LO)) begin
            rtb_lo_d = hwdata[31:RRPCI_RTB_LSB];
        end
        if (wr_now && hit(dadr_q, RRPCI_RTB_HI)) begin
            rtb_hi_d = hwdata[RRPCI_HI_W-1:0];
        end
        if (wr_now && hit(dadr_q, RRPCI_CFG)) begin
            flush_need_d = hwdata[RRPCI_FLSH_POS];
        end
        // copy taken a cycle after the command, so a base write in the
        // same cycle cannot race it
        if (load_q) begin
            act_lo_d = rtb_lo_q;
            act_hi_d = rtb_hi_q;
            ptr_stat_d = 1'b1;
        end
        if (wr_now && hit(dadr_q, RRPCI_CTRL) && hwdata[RRPCI_SETP_POS]) begin
            load_d     = 1'b1;
            ptr_stat_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rtb_lo_q <= '0;
            rtb_hi_q <= '0;
            act_lo_q <= '0;
            act_hi_q <= '0;
            load_q       <= 1'b0;
            ptr_stat_q   <= 1'b0;
            flush_need_q <= RRPCI_RST_FLSH;
        end else begin
            rtb_lo_q <= rtb_lo_d;
            rtb_hi_q <= rtb_hi_d;
            act_lo_q <= act_lo_d;
            act_hi_q <= act_hi_d;
            load_q       <= load_d;
            ptr_stat_q   <= ptr_stat_d;
            flush_need_q <= flush_need_d;
        end
    end

    assign active_root_ptr = {{(32 - RRPCI_HI_W){1'b0}}, act_hi_q, act_lo_q, {RRPCI_RTB_LSB{1'b0}}};

    // ****************************************************************
    // context command
    // ****************************************************************
    always_comb begin
        req_bit_d = req_bit_q;
        rgran_d   = rgran_q;
        agran_d   = agran_q;
        did_d   = did_q;
        sid_d   = sid_q;
        fm_d    = fm_q;
        start_d = 1'b0;
        // writes while a request is pending are dropped to protect it
        if (wr_now && !req_bit_q && hit(dadr_q, RRPCI_CCMD_LO)) begin
            did_d = hwdata[RRPCI_DID_LSB +: 16];
            sid_d = hwdata[RRPCI_SID_LSB +: 16];
        end
        if (wr_now && !req_bit_q && hit(dadr_q, RRPCI_CCMD_HI)) begin
            rgran_d = hwdata[RRPCI_RGRAN_LSB +: 2];
            fm_d    = hwdata[RRPCI_FM_LSB +: 2];
            if (hwdata[RRPCI_REQ_POS]) begin
                req_bit_d = 1'b1;
                start_d = 1'b1;
            end
        end
        if (ifc.done) begin
            req_bit_d = 1'b0;
            agran_d   = ifc.act_gran;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_bit_q <= 1'b0;
            rgran_q   <= RRPCI_GRAN_RSVD;
            agran_q   <= RRPCI_GRAN_RSVD;
            did_q   <= 16'h0000;
            sid_q   <= 16'h0000;
            fm_q    <= 2'h0;
            start_q <= 1'b0;
        end else begin
            req_bit_q <= req_bit_d;
            rgran_q   <= rgran_d;
            agran_q   <= agran_d;
            did_q   <= did_d;
            sid_q   <= sid_d;
            fm_q    <= fm_d;
            start_q <= start_d;
        end
    end

    assign ifc.start    = start_q;
    assign ifc.req_gran = rgran_q;
    assign ifc.domain_identifier      = did_q;
    assign ifc.sid      = sid_q;
    assign ifc.fm       = fm_q;
    assign ifc.flush_need = flush_need_q;

    rrpci_inval_eng u_eng (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ifc           (ifc.eng),
        .flush_req     (flush_req),
        .flush_ack     (flush_ack),
        .cc_inval_req  (cc_inval_req),
        .cc_inval_gran (cc_inval_gran),
        .cc_inval_did  (cc_inval_did),
        .cc_inval_sid  (cc_inval_sid),
        .cc_inval_fm   (cc_inval_fm),
        .cc_inval_ack  (cc_inval_ack)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence setptr_wr_s;
        wr_now && hit(dadr_q, RRPCI_CTRL) && hwdata[RRPCI_SETP_POS];
    endsequence

    sequence ptr_stat_s;
        !ptr_stat_q ##1 ptr_stat_q;
    endsequence

    base_store_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && hit(dadr_q, RRPCI_RTB_LO)) |=> rtb_lo_q == $past(hwdata[31:RRPCI_RTB_LSB]))
        else $error("root base not stored");

    base_readback_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hsel && htrans[1] && hready && !hwrite && haddr[RRPCI_AW-1:0] == RRPCI_RTB_LO)
        |=> hrdata[31:RRPCI_RTB_LSB] == $past(rtb_lo_q) && hrdata[RRPCI_RTB_LSB-1:0] == 12'h000)
        else $error("root base readback wrong");

    high_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (hsel && htrans[1] && hready && !hwrite && haddr[RRPCI_AW-1:0] == RRPCI_RTB_HI)
        |=> hrdata[31:RRPCI_HI_W] == '0)
        else $error("bits above host width not zero");

    ptr_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        setptr_wr_s |=> ptr_stat_s)
        else $error("root pointer status sequence wrong");

    ptr_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !load_q |=> $stable(active_root_ptr))
        else $error("active pointer moved without command");

    ptr_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        setptr_wr_s ##1 (!wr_now) |=> active_root_ptr[31:RRPCI_RTB_LSB] == rtb_lo_q)
        else $error("active pointer not loaded");

    reqbit_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_now && !req_bit_q && hit(dadr_q, RRPCI_CCMD_HI) && hwdata[RRPCI_REQ_POS])
        |=> req_bit_q && ifc.start ##1 !ifc.start)
        else $error("invalidation not started");

    reqbit_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (req_bit_q && !ifc.done) |=> req_bit_q)
        else $error("request bit dropped early");

    reqbit_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ifc.done |=> !req_bit_q && agran_q == $past(ifc.act_gran))
        else $error("completion not reported");

    busy_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        req_bit_q |=> $stable(rgran_q) && $stable(did_q))
        else $error("command changed while pending");

endmodule : rrpci_regs

// [sim/rrpci_regs_tb.sv]
`timescale 1ns/1ns
module rrpci_regs_tb
    import rrpci_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [63:0] active_root_ptr;
    logic        flush_req;
    logic        flush_ack;
    logic        cc_inval_req;
    logic [1:0]  cc_inval_gran;
    logic [15:0] cc_inval_did;
    logic [15:0] cc_inval_sid;
    logic [1:0]  cc_inval_fm;
    logic        cc_inval_ack;
    logic [31:0] rd;
    int          n_errors;
    int          check_count;

    rrpci_regs i_rrpci_regs (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .hsel            (hsel),
        .haddr           (haddr),
        .htrans          (htrans),
        .hwrite          (hwrite),
        .hsize           (hsize),
        .hwdata          (hwdata),
        .hready          (hreadyout),
        .hreadyout       (hreadyout),
        .hresp           (hresp),
        .hrdata          (hrdata),
        .active_root_ptr (active_root_ptr),
        .flush_req       (flush_req),
        .flush_ack       (flush_ack),
        .cc_inval_req    (cc_inval_req),
        .cc_inval_gran   (cc_inval_gran),
        .cc_inval_did    (cc_inval_did),
        .cc_inval_sid    (cc_inval_sid),
        .cc_inval_fm     (cc_inval_fm),
        .cc_inval_ack    (cc_inval_ack)
    );

    // ****************************************************************
    // clock, checking and closing
    // ****************************************************************
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // ****************************************************************
    // bus master: address phase held until hready, then data phase
    // ****************************************************************
    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d);
    endtask : wr32

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h00000000);
        chk("hresp okay", {63'h0, hresp}, 64'h0);
        chk(what, {32'h00000000, rd}, {32'h00000000, exp});
    endtask : rd_chk

    // bounded wait for a request level; 0 flush, 1 cache invalidation
    task automatic wait_req(input int which);
        int n;
        n = 0;
        while (((which == 0) ? flush_req : cc_inval_req) !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        chk("request raised", {63'h0, n < 50}, 64'h1);
    endtask : wait_req

    task automatic pulse_ack(input int which);
        if (which == 0) flush_ack <= 1'b1;
        else cc_inval_ack <= 1'b1;
        @(posedge hclk);
        flush_ack    <= 1'b0;
        cc_inval_ack <= 1'b0;
    endtask : pulse_ack

    // software side: poll until the request bit reads clear
    task automatic poll_done;
        int n;
        n = 0;
        do begin
            ahb_xfer(1'b0, RRPCI_CCMD_HI, 32'h00000000);
            n++;
        end while (rd[31] !== 1'b0 && n < 50);
        chk("request bit clear", {63'h0, n < 50}, 64'h1);
    endtask : poll_done

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        logic [1:0] ag;
        logic [1:0] pg;
        n_errors = 0;
        check_count = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        flush_ack = 1'b0;
        cc_inval_ack = 1'b0;
        pg = RRPCI_GRAN_RSVD;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;

        rd_chk("base lo reset", RRPCI_RTB_LO, 32'h00000000);
        rd_chk("base hi reset", RRPCI_RTB_HI, 32'h00000000);
        rd_chk("ccmd lo reset", RRPCI_CCMD_LO, 32'h00000000);
        rd_chk("ccmd hi reset", RRPCI_CCMD_HI, 32'h00000000);
        rd_chk("unmapped", 8'h44, 32'h00000000);
        $display("test reset values done");

        // base: low 12 bits reserved, bits above host width not kept
        wr32(RRPCI_RTB_LO, 32'hFFFFFFFF);
        wr32(RRPCI_RTB_HI, 32'hFFFFFFFF);
        rd_chk("base lo", RRPCI_RTB_LO, 32'hFFFFF000);
        rd_chk("base hi", RRPCI_RTB_HI, 32'h0000007F);
        chk("active before set", active_root_ptr, 64'h0);
        rd_chk("status before set", RRPCI_STAT, 32'h00000000);
        wr32(RRPCI_CTRL, 32'h40000000);
        rd_chk("status after set", RRPCI_STAT, 32'h40000000);
        chk("active loaded", active_root_ptr, 64'h0000007FFFFFF000);
        wr32(RRPCI_RTB_LO, 32'h12345000);
        rd_chk("base lo new", RRPCI_RTB_LO, 32'h12345000);
        rd_chk("active lo held", RRPCI_ACT_LO, 32'hFFFFF000);
        rd_chk("active hi", RRPCI_ACT_HI, 32'h0000007F);
        wr32(RRPCI_CTRL, 32'h40000000);
        rd_chk("active lo reloaded", RRPCI_ACT_LO, 32'h12345000);
        $display("test root pointer done");

        // every requested granularity code, no flush
        for (int g = 0; g < 4; g++) begin
            ag = (g == 0) ? RRPCI_GRAN_GLB : 2'(g);
            wr32(RRPCI_CCMD_LO, {16'hABCD, 16'h1230 + 16'(g)});
            wr32(RRPCI_CCMD_HI, 32'h80000003 | (32'(g) << 29));
            rd_chk("request pending", RRPCI_CCMD_HI, 32'h80000000 | (32'(g) << 29) | (32'(pg) << 27));
            wr32(RRPCI_CCMD_LO, 32'hFFFFFFFF);
            wait_req(1);
            chk("no flush", {63'h0, flush_req}, 64'h0);
            chk("gran out", {62'h0, cc_inval_gran}, {62'h0, ag});
            chk("did out", {48'h0, cc_inval_did}, {48'h0, 16'h1230 + 16'(g)});
            chk("sid out", {48'h0, cc_inval_sid}, 64'hABCD);
            chk("fm out", {62'h0, cc_inval_fm}, 64'h3);
            pulse_ack(1);
            poll_done();
            chk("ccmd hi done", {32'h0, rd}, {32'h0, (32'(g) << 29) | (32'(ag) << 27)});
            rd_chk("did kept", RRPCI_CCMD_LO, {16'h0000, 16'h1230 + 16'(g)});
            chk("inval idle", {63'h0, cc_inval_req}, 64'h0);
            pg = ag;
        end
        $display("test invalidation codes done");

        // flush required: flush handshake must finish before invalidation
        wr32(RRPCI_CFG, 32'h00000001);
        rd_chk("flush flag", RRPCI_CFG, 32'h00000001);
        wr32(RRPCI_CCMD_HI, 32'h80000000 | (32'(RRPCI_GRAN_DOM) << 29));
        wait_req(0);
        repeat (3) @(posedge hclk);
        chk("inval held during flush", {63'h0, cc_inval_req}, 64'h0);
        rd_chk("pending during flush", RRPCI_CCMD_HI, 32'hC0000000 | (32'(pg) << 27));
        pulse_ack(0);
        wait_req(1);
        chk("flush dropped", {63'h0, flush_req}, 64'h0);
        pulse_ack(1);
        poll_done();
        chk("flush done", {32'h0, rd}, 64'h50000000);
        $display("test flush then invalidation done");
        close_out();
    end

    // ****************************************************************
    // watchdog: the whole run needs under two hundred cycles
    // ****************************************************************
    initial begin
        #200000;
        n_errors++;
        $display("mismatch watchdog expected finish seen hang");
        close_out();
    end
endmodule : rrpci_regs_tb
